// ==== rtl/wsv_supervisor.sv ====
/*
 * wsv_supervisor: pin-selected watchdog supervisor top level.
 * Assumes synchronous pins and a 100 MHz CLK; the fault pin is resolved outside from its enable.
 */
`timescale 1ns/1ps
module wsv_supervisor import wsv_pkg::*; #(
    parameter wsv_variant_e VARIANT = VAR_GENERAL,
    parameter bit OPEN_DRAIN = 1'b1,
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic KICK_INPUT,
    input wire logic TIMING_SELECT_LOW,
    input wire logic TIMING_SELECT_MID,
    input wire logic TIMING_SELECT_HIGH,
    output logic FAULT_PULSE_OUT_N,
    output logic FAULT_PULSE_OE_N
);

    function automatic logic is_disabled(input logic [2:0] code);
        return code == SEL_DISABLED;
    endfunction

    function automatic logic is_first_edge(input logic [2:0] code);
        logic hit;
        hit = 1'b0;
        if (VARIANT == VAR_SHORT) begin
            hit = (code == 3'h5) || (code == 3'h6);
        end
        return hit;
    endfunction

    function automatic logic [CNT_W-1:0] startup_us(input logic [2:0] code);
        logic [CNT_W-1:0] t;
        t = T_60S;
        if (VARIANT == VAR_GENERAL) begin
            unique case (code)
                3'h0: t = T_1MS;
                3'h1: t = T_10MS;
                3'h2: t = T_30MS;
                3'h4: t = T_100MS;
                3'h5: t = T_1S;
                3'h6: t = T_10S;
                default: t = T_60S;
            endcase
        end else if (VARIANT == VAR_SHORT) begin
            unique case (code)
                3'h0: t = T_3MS;
                3'h1: t = T_3S;
                3'h4: t = T_200US;
                default: t = T_60S;
            endcase
        end
        return t;
    endfunction

    function automatic logic [CNT_W-1:0] timeout_us(input logic [2:0] code);
        logic [CNT_W-1:0] t;
        t = T_60S;
        if (VARIANT == VAR_GENERAL) begin
            unique case (code)
                3'h0: t = T_1MS;
                3'h1: t = T_10MS;
                3'h2: t = T_30MS;
                3'h4: t = T_100MS;
                3'h5: t = T_1S;
                3'h6: t = T_10S;
                default: t = T_60S;
            endcase
        end else if (VARIANT == VAR_LONG) begin
            unique case (code)
                3'h0: t = T_1MS;
                3'h1: t = T_3MS;
                3'h2: t = T_10MS;
                3'h4: t = T_100MS;
                3'h5: t = T_300MS;
                3'h6: t = T_3S;
                default: t = T_60S;
            endcase
        end else begin
            unique case (code)
                3'h0: t = T_3MS;
                3'h1: t = T_3S;
                3'h2: t = T_1S;
                3'h4: t = T_30US;
                3'h5: t = T_1S;
                default: t = T_10S;
            endcase
        end
        return t;
    endfunction

    localparam logic [CNT_W-1:0] T_PULSE = OPEN_DRAIN ? T_PULSE_OD_US : T_PULSE_PP_US;

    wsv_sel_s sel_in;
    wsv_sel_s sel_r;
    wsv_sel_s sel_nxt;
    wsv_state_e st_r;
    wsv_state_e st_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit;
    logic resume_r;
    logic resume_nxt;
    logic fault_r;
    logic fault_nxt;
    logic restart;
    logic tick;
    logic kick_edge;
    logic expire;
    logic changed;

    assign sel_in = '{high: TIMING_SELECT_HIGH, mid: TIMING_SELECT_MID, low: TIMING_SELECT_LOW};
    assign changed = sel_in != sel_r;

    wsv_timebase #(
        .TICK_CYCLES_P(TICK_CYCLES_P)
    ) u_timebase (
        .CLK(CLK),
        .RST_N(RST_N),
        .clear(restart),
        .tick(tick)
    );

    wsv_kick_edge u_kick (
        .CLK(CLK),
        .RST_N(RST_N),
        .kick(KICK_INPUT),
        .edge_seen(kick_edge)
    );

    // period length for the phase now running
    always_comb begin
        unique case (st_r)
            ST_SETUP: limit = T_SETUP_US;
            ST_START: limit = startup_us(sel_r);
            ST_WATCH: limit = timeout_us(sel_r);
            ST_FAULT: limit = T_PULSE;
            default: limit = T_60S;
        endcase
    end

    assign expire = tick && (cnt_r == limit - CNT_W'(1));

    always_comb begin
        st_nxt = st_r;
        resume_nxt = resume_r;
        fault_nxt = fault_r;
        sel_nxt = sel_in;
        restart = 1'b0;
        if (changed) begin
            // new setting: drop any pulse and reload from the setup interval
            st_nxt = ST_SETUP;
            resume_nxt = 1'b0;
            fault_nxt = 1'b1;
            restart = 1'b1;
        end else begin
            unique case (st_r)
                ST_SETUP: begin
                    // kicks are not looked at here at all
                    if (expire) begin
                        restart = 1'b1;
                        if (is_disabled(sel_r)) begin
                            st_nxt = ST_OFF;
                        end else if (resume_r) begin
                            st_nxt = ST_WATCH;
                        end else if (is_first_edge(sel_r)) begin
                            st_nxt = ST_FIRST;
                        end else begin
                            st_nxt = ST_START;
                        end
                    end
                end
                ST_START: begin
                    if (expire) begin
                        st_nxt = ST_WATCH;
                        restart = 1'b1;
                    end
                end
                ST_FIRST: begin
                    if (kick_edge) begin
                        st_nxt = ST_WATCH;
                        restart = 1'b1;
                    end
                end
                ST_WATCH: begin
                    // a kick in the expiry cycle still counts
                    if (kick_edge) begin
                        restart = 1'b1;
                    end else if (expire) begin
                        st_nxt = ST_FAULT;
                        fault_nxt = 1'b0;
                        restart = 1'b1;
                    end
                end
                ST_FAULT: begin
                    if (expire) begin
                        st_nxt = ST_SETUP;
                        resume_nxt = 1'b1;
                        fault_nxt = 1'b1;
                        restart = 1'b1;
                    end
                end
                ST_OFF: begin
                    fault_nxt = 1'b1;
                end
                default: begin
                    st_nxt = ST_SETUP;
                    restart = 1'b1;
                end
            endcase
        end
        if (restart) begin
            cnt_nxt = '0;
        end else if (tick) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_r <= ST_SETUP;
            sel_r <= SEL_RESET;
            cnt_r <= '0;
            resume_r <= 1'b0;
            fault_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            sel_r <= sel_nxt;
            cnt_r <= cnt_nxt;
            resume_r <= resume_nxt;
            fault_r <= fault_nxt;
        end
    end

    // open drain only drives while pulling low; push-pull drives always
    assign FAULT_PULSE_OUT_N = fault_r;
    assign FAULT_PULSE_OE_N = OPEN_DRAIN ? fault_r : 1'b0;

endmodule

// ==== rtl/wsv_pkg.sv ====
/*
 * wsv_pkg: constants, tables and types for the pin-selected watchdog supervisor.
 * Assumes a 100 MHz CLK; all periods are counted in 1 us ticks of an internal time base.
 */
package wsv_pkg;

    localparam int CNT_W = 28;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

    // all table values are the minimum of each printed range, so no fault fires early
    localparam logic [CNT_W-1:0] T_SETUP_US = 28'h0000064;
    localparam logic [CNT_W-1:0] T_PULSE_OD_US = 28'h00186A0;
    localparam logic [CNT_W-1:0] T_PULSE_PP_US = 28'h00003E8;
    localparam logic [CNT_W-1:0] T_30US = 28'h000001E;
    localparam logic [CNT_W-1:0] T_200US = 28'h00000C8;
    localparam logic [CNT_W-1:0] T_1MS = 28'h00003E8;
    localparam logic [CNT_W-1:0] T_3MS = 28'h0000BB8;
    localparam logic [CNT_W-1:0] T_10MS = 28'h0002710;
    localparam logic [CNT_W-1:0] T_30MS = 28'h0007530;
    localparam logic [CNT_W-1:0] T_100MS = 28'h00186A0;
    localparam logic [CNT_W-1:0] T_300MS = 28'h00493E0;
    localparam logic [CNT_W-1:0] T_1S = 28'h00F4240;
    localparam logic [CNT_W-1:0] T_3S = 28'h02DC6C0;
    localparam logic [CNT_W-1:0] T_10S = 28'h0989680;
    localparam logic [CNT_W-1:0] T_60S = 28'h3938700;

    localparam logic [2:0] SEL_DISABLED = 3'h3;
    localparam logic [2:0] SEL_RESET = 3'h0;

    typedef enum logic [1:0] {
        VAR_GENERAL = 2'h0,
        VAR_LONG = 2'h1,
        VAR_SHORT = 2'h2
    } wsv_variant_e;

    typedef enum logic [5:0] {
        ST_SETUP = 6'h01,
        ST_START = 6'h02,
        ST_FIRST = 6'h04,
        ST_WATCH = 6'h08,
        ST_FAULT = 6'h10,
        ST_OFF = 6'h20
    } wsv_state_e;

    typedef struct packed {
        logic high;
        logic mid;
        logic low;
    } wsv_sel_s;

endpackage

// ==== rtl/wsv_timebase.sv ====
/*
 * wsv_timebase: divides CLK down to a one-cycle tick every TICK_CYCLES cycles.
 * Assumes the caller pulses clear whenever a new period begins.
 */
`timescale 1ns/1ps
module wsv_timebase import wsv_pkg::*; #(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic clear,
    output logic tick
);
    localparam int PW = $clog2(TICK_CYCLES_P + 1);
    localparam logic [PW-1:0] LAST = PW'(TICK_CYCLES_P - 1);

    logic [PW-1:0] pre_r;
    logic [PW-1:0] pre_nxt;

    // clearing on period start keeps every period at least its full length
    always_comb begin
        if (clear || pre_r == LAST) begin
            pre_nxt = '0;
        end else begin
            pre_nxt = pre_r + PW'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    // tick must not look at clear: clear is built from tick upstream, a loop otherwise;
    // the caller lets its own restart win over a tick in the same cycle
    assign tick = pre_r == LAST;
endmodule

// ==== rtl/wsv_kick_edge.sv ====
/*
 * wsv_kick_edge: registers the kick input and flags each level transition.
 * Assumes the kick input is synchronous to CLK.
 */
`timescale 1ns/1ps
module wsv_kick_edge (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic kick,
    output logic edge_seen
);
    logic kick_r;
    logic prev_r;
    logic kick_nxt;
    logic prev_nxt;
    logic prime_r;
    logic prime_nxt;

    always_comb begin
        kick_nxt = kick;
        // first cycle after reset loads both stages from the pin, so no false edge
        prev_nxt = prime_r ? kick_r : kick;
        prime_nxt = 1'b1;
    end

    // prime blocks a false edge from the reset value of the history
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            kick_r <= 1'b0;
            prev_r <= 1'b0;
            prime_r <= 1'b0;
        end else begin
            kick_r <= kick_nxt;
            prev_r <= prev_nxt;
            prime_r <= prime_nxt;
        end
    end

    assign edge_seen = prime_r && (kick_r != prev_r);
endmodule

// ==== test/wsv_proc_model.sv ====
/* wsv_proc_model: supervised processor that toggles the kick pin every period cycles.
   Assumes enable and period are steady levels from the bench. */
`timescale 1ns/1ps
module wsv_proc_model (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic enable,
    input wire logic [15:0] period,
    output logic kick
);
    logic kick_r = 1'b0;
    logic [15:0] cnt_r = 16'h0000;
    assign kick = kick_r;
    // kick level is held between toggles, so the pin never floats
    always @(posedge CLK) begin
        if (!RST_N || !enable) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r + 16'h0001 >= period) begin
            cnt_r <= 16'h0000;
            kick_r <= ~kick_r;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule

// ==== test/wsv_supervisor_checker.sv ====
/* wsv_supervisor_checker: pin-level timing assertions for the supervisor.
   Assumes the general timing tables; bounds carry a few cycles of slack. */
`timescale 1ns/1ps
module wsv_supervisor_checker #(
    parameter bit OPEN_DRAIN = 1'b1,
    parameter int TICK_CYCLES_P = 100
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic KICK_INPUT,
    input wire logic TIMING_SELECT_LOW,
    input wire logic TIMING_SELECT_MID,
    input wire logic TIMING_SELECT_HIGH,
    input wire logic FAULT_PULSE_OUT_N,
    input wire logic FAULT_PULSE_OE_N
);
    localparam int PW = (OPEN_DRAIN ? 100000 : 1000) * TICK_CYCLES_P;
    localparam int TO = 1000 * TICK_CYCLES_P;
    localparam int SU = 100 * TICK_CYCLES_P;
    logic [2:0] sel;
    logic [2:0] sel_q_r;
    logic kick_q_r;
    logic moved_r, moved_nxt;
    logic [31:0] rst_r, rst_nxt, kick_r, kick_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
    assign sel = {TIMING_SELECT_HIGH, TIMING_SELECT_MID, TIMING_SELECT_LOW};
    always_comb begin
        rst_nxt = rst_r + 32'h1;
        kick_nxt = (KICK_INPUT != kick_q_r) ? 32'h0 : kick_r + 32'h1;
        hi_nxt = FAULT_PULSE_OUT_N ? hi_r + 32'h1 : 32'h0;
        lo_nxt = FAULT_PULSE_OUT_N ? 32'h0 : lo_r + 32'h1;
        // a select change cuts the pulse short, so the width floor is waived
        moved_nxt = !FAULT_PULSE_OUT_N && (moved_r || sel != sel_q_r);
        if (!RST_N) begin
            rst_nxt = 32'h0;
            kick_nxt = 32'h0;
            hi_nxt = 32'h0;
        end
    end
    always_ff @(posedge CLK) begin
        sel_q_r <= sel;
        kick_q_r <= KICK_INPUT;
        rst_r <= rst_nxt;
        kick_r <= kick_nxt;
        hi_r <= hi_nxt;
        lo_r <= lo_nxt;
        moved_r <= moved_nxt;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_reset_high: assert property ($rose(RST_N) |-> FAULT_PULSE_OUT_N)
        else $error("fault pin not idle after reset");
    a_oe_mode: assert property (FAULT_PULSE_OE_N == (OPEN_DRAIN ? FAULT_PULSE_OUT_N : 1'b0))
        else $error("drive enable does not match output style");
    a_disabled_quiet: assert property (sel == 3'h3 && $past(sel) == 3'h3
        && $past(sel, 2) == 3'h3 && FAULT_PULSE_OUT_N |=> FAULT_PULSE_OUT_N)
        else $error("fault pulse while disabled");
    a_kick_restarts: assert property ($fell(FAULT_PULSE_OUT_N) |-> kick_r >= TO - 4)
        else $error("fault too soon after a kick");
    a_startup_hold: assert property ($fell(FAULT_PULSE_OUT_N) |-> rst_r >= SU + 2 * TO - 4)
        else $error("fault before startup delay and timeout");
    a_fault_gap: assert property ($fell(FAULT_PULSE_OUT_N) |-> hi_r >= SU + TO - 4)
        else $error("fault too soon after previous pulse");
    a_pulse_max: assert property (lo_r <= PW + 4)
        else $error("fault pulse too long");
    a_pulse_min: assert property ($rose(FAULT_PULSE_OUT_N) && !moved_r |-> lo_r >= PW - 4)
        else $error("fault pulse too short");
    cover property ($fell(FAULT_PULSE_OUT_N));
    cover property ($rose(FAULT_PULSE_OUT_N) && !moved_r);
    cover property ($rose(FAULT_PULSE_OUT_N) && moved_r);
    cover property (sel == 3'h3 && FAULT_PULSE_OUT_N);
endmodule
bind wsv_supervisor wsv_supervisor_checker #(.OPEN_DRAIN(OPEN_DRAIN),
    .TICK_CYCLES_P(TICK_CYCLES_P)) wsv_supervisor_checker_inst (.CLK(CLK), .RST_N(RST_N),
    .KICK_INPUT(KICK_INPUT), .TIMING_SELECT_LOW(TIMING_SELECT_LOW),
    .TIMING_SELECT_MID(TIMING_SELECT_MID), .TIMING_SELECT_HIGH(TIMING_SELECT_HIGH),
    .FAULT_PULSE_OUT_N(FAULT_PULSE_OUT_N), .FAULT_PULSE_OE_N(FAULT_PULSE_OE_N));

// ==== test/testbench.sv ====
/* testbench: directed scenarios for a push-pull general build with a 2-cycle tick.
   Assumes the processor model supplies kicks; CLK 100 MHz. */
`timescale 1ns/1ps
module testbench;
    import wsv_pkg::*;
    localparam int TK = 2;
    localparam int SU = 100 * TK;
    localparam int TO = 1000 * TK;
    localparam int PW = 1000 * TK;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic kick_en = 1'b0;
    logic kick;
    wsv_sel_s sel = 3'h0;
    logic out_n;
    logic oe_n;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    always #5 CLK = ~CLK;
    wsv_proc_model wsv_proc_model_inst (.CLK(CLK), .RST_N(RST_N), .enable(kick_en),
        .period(16'h01F4), .kick(kick));
    wsv_supervisor #(.OPEN_DRAIN(1'b0), .TICK_CYCLES_P(TK)) wsv_supervisor_inst (
        .CLK(CLK), .RST_N(RST_N), .KICK_INPUT(kick), .TIMING_SELECT_LOW(sel.low),
        .TIMING_SELECT_MID(sel.mid), .TIMING_SELECT_HIGH(sel.high),
        .FAULT_PULSE_OUT_N(out_n), .FAULT_PULSE_OE_N(oe_n));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s: expected %0d, seen %0d", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // n counts cycles until the fault pin reaches lvl or lim runs out
    task automatic wait_pin(input logic lvl, input int lim);
        n = 0;
        while (out_n !== lvl && n < lim) begin
            @(posedge CLK);
            #1;
            n++;
        end
    endtask
    function automatic logic near(input int got, input int exp);
        return got >= exp - 12 && got <= exp + 12;
    endfunction
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            summarize();
        end
    end
    task automatic t_startup();
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        #1;
        check("idle pin", out_n, 1'b1);
        check("drive enable", oe_n, 1'b0);
        wait_pin(1'b0, 9000);
        check("startup expiry", near(n, SU + 2 * TO), 1'b1);
        wait_pin(1'b1, 9000);
        check("pulse width", near(n, PW), 1'b1);
        wait_pin(1'b0, 9000);
        check("refault", near(n, SU + TO), 1'b1);
    endtask
    task automatic t_kick();
        wait_pin(1'b1, 9000);
        @(posedge CLK);
        kick_en <= 1'b1;
        wait_pin(1'b0, 6000);
        check("fault while kicked", out_n, 1'b1);
        @(posedge CLK);
        kick_en <= 1'b0;
        wait_pin(1'b0, 9000);
        check("missed kick", n >= TO - 520 && n <= TO + 12, 1'b1);
    endtask
    task automatic t_disable();
        @(posedge CLK);
        sel <= 3'h3;
        wait_pin(1'b1, 8);
        check("cancelled pulse", out_n, 1'b1);
        wait_pin(1'b0, 8000);
        check("disabled pin", out_n, 1'b1);
        @(posedge CLK);
        sel <= 3'h1;
        wait_pin(1'b0, 45000);
        check("new setting expiry", near(n, SU + 20 * TO), 1'b1);
    endtask
    initial begin
        t_startup();
        t_kick();
        t_disable();
        summarize();
    end
endmodule
